// >>> src/triggered_measurement_sequencer.sv
// Start-triggered delay, sampling and shot bookkeeping sequencer.
// Assumes inPort comes from outside pins; all other inputs are
// same-clock configuration or judgement logic.
`timescale 1ns/10ps
module triggered_measurement_sequencer #(
  parameter int MS_CYCLES_P = tms_pkg::MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [tms_pkg::N_PORTS-1:0] inPort,
  input wire logic [tms_pkg::N_PORTS-1:0] trigEnable,
  input wire logic [3:0] chTrigSel [tms_pkg::N_CH],
  input wire tms_pkg::out_func_t outFunc [tms_pkg::N_PORTS],
  input wire logic [23:0] measTime,
  input wire logic [3:0] sampleSel,
  input wire tms_pkg::p_unit_t unitSel,
  input wire logic [7:0] delayTenths,
  input wire logic [15:0] alarmWidthMs,
  input wire logic [7:0] alarmLimit,
  input wire logic [15:0] shotWidthMs,
  input wire logic [23:0] schedShots,
  input wire logic countClear,
  input wire logic shotError,
  input wire logic [15:0] pressRaw,
  output logic [tms_pkg::N_PORTS-1:0] outPort,
  output logic [tms_pkg::N_CH-1:0] chMeasuring,
  output logic sampleStrobe,
  output logic measuring,
  output logic [23:0] shotCount,
  output logic [23:0] pressOut,
  output logic pressValid
);
  import tms_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [N_PORTS-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt, rise;

  always_comb begin
    lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    rise = s2_r & s3_r & ~lvl_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= inPort;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and shot bookkeeping
  // ----------------------------------------------------------------
  seq_state_t state_r, state_nxt;
  logic [15:0] div_r, div_nxt;
  logic [27:0] elapsed_r, elapsed_nxt;
  logic [27:0] delayTarget_r, delayTarget_nxt;
  logic [27:0] measTarget_r, measTarget_nxt;
  logic [3:0] sel_r, sel_nxt;
  logic [9:0] phase_r, phase_nxt;
  logic [N_CH-1:0] ch_r, ch_nxt, chStart;
  logic sample_r, sample_nxt;
  logic [7:0] errCnt_r, errCnt_nxt;
  logic [15:0] alarmTmr_r, alarmTmr_nxt, shotTmr_r, shotTmr_nxt;
  logic [23:0] count_r, count_nxt;
  logic prod_r, prod_nxt, meas_r, meas_nxt;
  logic [N_PORTS-1:0] out_r, out_nxt;
  logic msTick, trigRise, shotEvt;
  logic [23:0] timeClamp;

  always_comb begin
    trigRise = |(rise & trigEnable);
    for (int c = 0; c < N_CH; c++) begin
      chStart[c] = chTrigSel[c] < 4'(N_PORTS)
        && rise[chTrigSel[c]] && trigEnable[chTrigSel[c]];
    end
    timeClamp = measTime < 24'(TIME_MIN) ? 24'(TIME_MIN) : measTime;
    if (timeClamp > maxTime(sampleSel)) begin
      timeClamp = maxTime(sampleSel);
    end
    msTick = div_r == 16'(MS_CYCLES_P - 1);
    div_nxt = msTick ? 16'h0000 : div_r + 16'h0001;
    state_nxt = state_r;
    elapsed_nxt = elapsed_r;
    delayTarget_nxt = delayTarget_r;
    measTarget_nxt = measTarget_r;
    sel_nxt = sel_r;
    phase_nxt = phase_r;
    ch_nxt = ch_r;
    sample_nxt = 1'b0;
    shotEvt = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (trigRise) begin
          state_nxt = ST_DELAY;
          div_nxt = 16'h0000;
          elapsed_nxt = 28'h0000000;
          ch_nxt = chStart;
          sel_nxt = sampleSel;
          measTarget_nxt = 28'(timeClamp * TIME_STEP_MS);
          delayTarget_nxt = 28'((delayTenths > 8'(DELAY_MAX) ?
            8'(DELAY_MAX) : delayTenths) * DELAY_STEP_MS);
        end
      end
      ST_DELAY: begin
        if (elapsed_r >= delayTarget_r) begin
          state_nxt = ST_MEAS;
          div_nxt = 16'h0000;
          elapsed_nxt = 28'h0000000;
          phase_nxt = 10'h000;
          sample_nxt = 1'b1;
        end else if (msTick) begin
          elapsed_nxt = elapsed_r + 28'h0000001;
        end
      end
      ST_MEAS: begin
        if (msTick) begin
          if (elapsed_r + 28'h0000001 >= measTarget_r) begin
            state_nxt = ST_IDLE;
            ch_nxt = '0;
            shotEvt = 1'b1;
          end else begin
            elapsed_nxt = elapsed_r + 28'h0000001;
            if (phase_r == periodMs(sel_r) - 10'h001) begin
              phase_nxt = 10'h000;
              sample_nxt = 1'b1;
            end else begin
              phase_nxt = phase_r + 10'h001;
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        ch_nxt = '0;
      end
    endcase

    alarmTmr_nxt = alarmTmr_r;
    shotTmr_nxt = shotTmr_r;
    if (msTick && alarmTmr_r != 16'h0000) begin
      alarmTmr_nxt = alarmTmr_r - 16'h0001;
    end
    if (msTick && shotTmr_r != 16'h0000) begin
      shotTmr_nxt = shotTmr_r - 16'h0001;
    end
    errCnt_nxt = errCnt_r;
    count_nxt = countClear ? 24'h000000 : count_r;
    if (shotEvt) begin
      shotTmr_nxt = shotWidthMs;
      if (count_nxt != 24'hffffff) begin
        count_nxt = count_nxt + 24'h000001;
      end
      if (shotError) begin
        if (errCnt_r != 8'hff) begin
          errCnt_nxt = errCnt_r + 8'h01;
        end
        if (errCnt_nxt > alarmLimit) begin
          alarmTmr_nxt = alarmWidthMs;
        end
      end else begin
        errCnt_nxt = 8'h00;
      end
    end
    prod_nxt = schedShots != 24'h000000 && count_nxt >= schedShots;
    meas_nxt = state_nxt == ST_MEAS;
    for (int p = 0; p < N_PORTS; p++) begin
      unique case (outFunc[p])
        OUT_ALARM: out_nxt[p] = alarmTmr_nxt != 16'h0000;
        OUT_SHOT: out_nxt[p] = shotTmr_nxt != 16'h0000;
        OUT_PROD: out_nxt[p] = prod_nxt;
        OUT_BUSY: out_nxt[p] = state_nxt != ST_IDLE;
        default: out_nxt[p] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      div_r <= 16'h0000;
      elapsed_r <= 28'h0000000;
      delayTarget_r <= 28'h0000000;
      measTarget_r <= 28'h0000000;
      sel_r <= 4'h0;
      phase_r <= 10'h000;
      ch_r <= '0;
      sample_r <= 1'b0;
      errCnt_r <= 8'h00;
      alarmTmr_r <= 16'h0000;
      shotTmr_r <= 16'h0000;
      count_r <= 24'h000000;
      prod_r <= 1'b0;
      meas_r <= 1'b0;
      out_r <= '0;
    end else begin
      state_r <= state_nxt;
      div_r <= div_nxt;
      elapsed_r <= elapsed_nxt;
      delayTarget_r <= delayTarget_nxt;
      measTarget_r <= measTarget_nxt;
      sel_r <= sel_nxt;
      phase_r <= phase_nxt;
      ch_r <= ch_nxt;
      sample_r <= sample_nxt;
      errCnt_r <= errCnt_nxt;
      alarmTmr_r <= alarmTmr_nxt;
      shotTmr_r <= shotTmr_nxt;
      count_r <= count_nxt;
      prod_r <= prod_nxt;
      meas_r <= meas_nxt;
      out_r <= out_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Unit conversion and outputs
  // ----------------------------------------------------------------
  conv_if cv ();
  assign cv.raw = pressRaw;
  assign cv.unit = unitSel;
  assign cv.load = sample_r;
  unit_converter u_conv (
    .ref_clk(ref_clk),
    .srst(srst),
    .cv(cv)
  );
  assign outPort = out_r;
  assign chMeasuring = ch_r;
  assign sampleStrobe = sample_r;
  assign measuring = meas_r;
  assign shotCount = count_r;
  assign pressOut = cv.value;
  assign pressValid = cv.valid;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  sequence s_accept;
    state_r == ST_IDLE && trigRise;
  endsequence
  sequence s_finish;
    state_r == ST_MEAS && msTick && elapsed_r + 28'h0000001 >= measTarget_r;
  endsequence
  a_trig_start: assert property (s_accept |=> state_r == ST_DELAY
    && ch_r == $past(chStart)) else $error("trigger not taken");
  a_trig_ignored: assert property (state_r != ST_IDLE && trigRise
    |=> $stable(ch_r) || state_r == ST_IDLE)
    else $error("trigger not ignored");
  a_delay_bound: assert property (state_r == ST_DELAY
    |-> elapsed_r <= delayTarget_r) else $error("delay overrun");
  a_meas_bound: assert property (state_r == ST_MEAS
    |-> elapsed_r < measTarget_r) else $error("measurement overrun");
  a_time_limit: assert property (state_r != ST_IDLE
    |-> measTarget_r <= 28'(maxTime(sel_r) * TIME_STEP_MS))
    else $error("time above interval limit");
  a_first_sample: assert property ($rose(state_r == ST_MEAS)
    |-> sample_r) else $error("no sample at measurement start");
  a_shot_pulse: assert property (s_finish ##1 state_r == ST_IDLE
    |-> shotTmr_r == $past(shotWidthMs)) else $error("shot pulse missing");
  a_alarm_load: assert property (s_finish and shotError
    && errCnt_r >= alarmLimit && errCnt_r != 8'hff |=> alarmTmr_r ==
    $past(alarmWidthMs)) else $error("alarm not raised");
  a_err_clear: assert property (s_finish and !shotError
    |=> errCnt_r == 8'h00) else $error("error count not cleared");
  a_prod_flag: assert property (##1 prod_r == ($past(schedShots) != 0
    && count_r >= $past(schedShots))) else $error("production flag wrong");
endmodule

// >>> include/tms_pkg.sv
// Constants, types and helpers of the triggered measurement sequencer.
// Assumes one 40 MHz clock; all ports except inPort belong to that clock's domain.
package tms_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int DELAY_STEP_MS = 100;
  localparam int DELAY_MAX = 250;
  localparam int TIME_STEP_MS = 10;
  localparam int TIME_MIN = 1;
  localparam int TIME_MAX = 12_000_000;
  localparam int LIMIT_STEPS_PER_MS = 12_000;
  // ----------------------------------------------------------------
  // Sizes and codes
  // ----------------------------------------------------------------
  localparam int N_PORTS = 10;
  localparam int N_CH = 8;
  localparam int Q_SHIFT = 8;
  localparam logic [15:0] K_MPA = 16'h0100;
  localparam logic [15:0] K_KGF = 16'h0a32;
  localparam logic [15:0] K_PSI = 16'h910a;
  localparam logic [15:0] K_BAR = 16'h0a00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DELAY = 3'b010,
    ST_MEAS = 3'b100
  } seq_state_t;

  typedef enum logic [2:0] {
    OUT_NONE = 3'h0,
    OUT_ALARM = 3'h1,
    OUT_SHOT = 3'h2,
    OUT_PROD = 3'h3,
    OUT_BUSY = 3'h4
  } out_func_t;

  typedef enum logic [1:0] {
    UNIT_MPA = 2'h0,
    UNIT_KGF = 2'h1,
    UNIT_PSI = 2'h2,
    UNIT_BAR = 2'h3
  } p_unit_t;

  // Sampling period in ms for a selector code
  function automatic logic [9:0] periodMs(input logic [3:0] sel);
    case (sel)
      4'h0: periodMs = 10'h001;
      4'h1: periodMs = 10'h002;
      4'h2: periodMs = 10'h005;
      4'h3: periodMs = 10'h00a;
      4'h4: periodMs = 10'h014;
      4'h5: periodMs = 10'h032;
      4'h6: periodMs = 10'h064;
      4'h7: periodMs = 10'h0c8;
      4'h8: periodMs = 10'h1f4;
      default: periodMs = 10'h3e8;
    endcase
  endfunction

  // Longest measurement time, in 10 ms steps, for a sampling period
  function automatic logic [23:0] maxTime(input logic [3:0] sel);
    maxTime = 24'(int'(periodMs(sel)) * LIMIT_STEPS_PER_MS);
  endfunction
endpackage

// >>> include/conv_if.sv
// Carrier between the sequencer and its pressure unit converter.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface conv_if;
  import tms_pkg::*;
  logic [15:0] raw;
  p_unit_t unit;
  logic load;
  logic [23:0] value;
  logic valid;
  modport src (output raw, output unit, output load,
    input value, input valid);
  modport conv (input raw, input unit, input load,
    output value, output valid);
endinterface

// >>> src/unit_converter.sv
// Converts a raw pressure sample (0.001 MPa) to the selected unit.
// Assumes load is a one-cycle pulse on the same clock.
`timescale 1ns/10ps
module unit_converter (
  input wire logic ref_clk,
  input wire logic srst,
  conv_if.conv cv
);
  import tms_pkg::*;
  logic [23:0] value_r, value_nxt;
  logic valid_r, valid_nxt;
  logic [15:0] k;
  logic [31:0] prod;

  always_comb begin
    unique case (cv.unit)
      UNIT_MPA: k = K_MPA;
      UNIT_KGF: k = K_KGF;
      UNIT_PSI: k = K_PSI;
      UNIT_BAR: k = K_BAR;
    endcase
    prod = cv.raw * k;
    valid_nxt = cv.load;
    value_nxt = value_r;
    if (cv.load) begin
      value_nxt = prod[Q_SHIFT +: 24];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      value_r <= 24'h000000;
      valid_r <= 1'b0;
    end else begin
      value_r <= value_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign cv.value = value_r;
  assign cv.valid = valid_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_unit_mpa: assert property (cv.load && cv.unit == UNIT_MPA
    |=> cv.valid && cv.value == {8'h00, $past(cv.raw)})
    else $error("MPa sample not passed through");
  a_unit_bar: assert property (cv.load && cv.unit == UNIT_BAR
    |=> cv.value == 24'($past(cv.raw) * 10))
    else $error("bar sample not scaled by ten");
endmodule

// >>> verification/mold_machine.sv
// Molding machine model that drives the start trigger pins.
// Assumes busy is high from trigger acceptance to measurement end.
`timescale 1ns/10ps
module mold_machine #(
  parameter int GAP = 200,
  parameter int CYCLE = 10000
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic busy,
  input wire logic kick,
  input wire logic rude,
  input wire logic [3:0] kickPort,
  output logic [9:0] pins
);
  int sinceEnd;
  int sinceStart;
  int hold;
  logic pend;
  logic pendRude;
  logic [3:0] port;

  // Released pins fall to the pull-down level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sinceEnd <= GAP;
      sinceStart <= CYCLE;
      hold <= 0;
      pend <= 1'b0;
      pendRude <= 1'b0;
      port <= 4'h0;
      pins <= '0;
    end else begin
      if (busy) begin
        sinceEnd <= 0;
      end else if (sinceEnd < GAP) begin
        sinceEnd <= sinceEnd + 1;
      end
      if (sinceStart < CYCLE) begin
        sinceStart <= sinceStart + 1;
      end
      if (kick) begin
        pend <= 1'b1;
        pendRude <= rude;
        port <= kickPort;
      end
      if (hold > 0) begin
        hold <= hold - 1;
        if (hold == 1) begin
          pins <= '0;
        end
      end else if (pend && (pendRude || (!busy && sinceEnd >= GAP
          && sinceStart >= CYCLE))) begin
        pins <= 10'(1) << port;
        hold <= 8;
        pend <= 1'b0;
        sinceStart <= 0;
      end
    end
  end
endmodule

// >>> verification/tb.sv
// Self-checking bench of the triggered measurement sequencer.
// Assumes a 1 ms tick of 10 clocks and the machine model on inPort.
`timescale 1ns/10ps
module tb;
  import tms_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int MSC = 10;
  localparam int LIMIT = 70000;
  logic ref_clk, srst, kick, rude, countClear, shotError, alarmSeen;
  logic [3:0] kickPort, sampleSel;
  logic [N_PORTS-1:0] inPort, trigEnable, outPort;
  logic [3:0] chTrigSel [N_CH];
  out_func_t outFunc [N_PORTS];
  p_unit_t unitSel;
  logic [23:0] measTime, schedShots, shotCount, pressOut;
  logic [7:0] delayTenths, alarmLimit;
  logic [15:0] alarmWidthMs, shotWidthMs, pressRaw;
  logic [N_CH-1:0] chMeasuring;
  logic sampleStrobe, measuring, pressValid;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  triggered_measurement_sequencer #(.MS_CYCLES_P(MSC)) DUT (
    .ref_clk(ref_clk), .srst(srst), .inPort(inPort),
    .trigEnable(trigEnable), .chTrigSel(chTrigSel), .outFunc(outFunc),
    .measTime(measTime), .sampleSel(sampleSel), .unitSel(unitSel),
    .delayTenths(delayTenths), .alarmWidthMs(alarmWidthMs),
    .alarmLimit(alarmLimit), .shotWidthMs(shotWidthMs),
    .schedShots(schedShots), .countClear(countClear),
    .shotError(shotError), .pressRaw(pressRaw), .outPort(outPort),
    .chMeasuring(chMeasuring), .sampleStrobe(sampleStrobe),
    .measuring(measuring), .shotCount(shotCount), .pressOut(pressOut),
    .pressValid(pressValid));

  mold_machine #(.GAP(20 * MSC), .CYCLE(1000 * MSC)) machine (
    .ref_clk(ref_clk), .srst(srst), .busy(|chMeasuring), .kick(kick),
    .rude(rude), .kickPort(kickPort), .pins(inPort));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [23:0] expConv(input int u);
    logic [31:0] k;
    k = (u == 0) ? 32'(K_MPA) : (u == 1) ? 32'(K_KGF) :
        (u == 2) ? 32'(K_PSI) : 32'(K_BAR);
    expConv = 24'((32'h0000_03e8 * k) >> Q_SHIFT);
  endfunction

  // One shot: trigger, delay, measurement and output pulses
  task automatic run_shot(input logic [3:0] port, input logic err,
      input logic rudeKick);
    int t, dly, dur, s1, s2, shotLen, alLen, e;
    shotError = err;
    kickPort = port;
    kick = 1'b1;
    @(negedge ref_clk);
    kick = 1'b0;
    t = 0;
    while (chMeasuring == '0 && t < 12000) begin
      @(negedge ref_clk);
      t++;
    end
    check(32'(chMeasuring), 32'(1) << port);
    e = int'(delayTenths) * 100 * MSC;
    dly = 0;
    while (!measuring && dly < 30000) begin
      @(negedge ref_clk);
      dly++;
    end
    check(32'(dly >= e && dly <= e + 1), 32'h1);
    dur = 0;
    s1 = -1;
    s2 = -1;
    while (measuring && dur < 1000) begin
      if (sampleStrobe === 1'b1) begin
        if (s1 < 0) s1 = dur;
        else if (s2 < 0) s2 = dur;
      end
      if (dur == 10) check(32'(outPort[3]), 32'h1);
      if (dur < 2) check(32'(pressValid), 32'(dur == 1));
      kick = rudeKick && dur == 50;
      rude = kick;
      @(negedge ref_clk);
      dur++;
    end
    kick = 1'b0;
    rude = 1'b0;
    check(dur, 200);
    check(s2 - s1, 20);
    shotLen = 0;
    alLen = 0;
    repeat (400) begin
      @(negedge ref_clk);
      shotLen += int'(outPort[1]);
      alLen += int'(outPort[0]);
    end
    check(32'(shotLen >= 20 && shotLen <= 31), 32'h1);
    alarmSeen = alLen > 0;
    if (alarmSeen) check(32'(alLen >= 10 && alLen <= 21), 32'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1;
    kick = 1'b0;
    rude = 1'b0;
    kickPort = 4'h0;
    countClear = 1'b0;
    shotError = 1'b0;
    trigEnable = 10'h003;
    for (int i = 0; i < N_CH; i++) chTrigSel[i] = (i < 2) ? 4'(i) : 4'hf;
    for (int i = 0; i < N_PORTS; i++) begin
      outFunc[i] = (i < 4) ? out_func_t'(i + 1) : OUT_NONE;
    end
    measTime = 24'h000002;
    sampleSel = 4'h1;
    unitSel = UNIT_MPA;
    delayTenths = 8'h00;
    alarmWidthMs = 16'h0002;
    alarmLimit = 8'h01;
    shotWidthMs = 16'h0003;
    schedShots = 24'h000005;
    pressRaw = 16'h03e8;
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    check(32'(outPort), 32'h0);
    check(32'(shotCount), 32'h0);
    for (int u = 0; u < 4; u++) begin
      unitSel = p_unit_t'(u);
      run_shot(4'h0, u == 1 || u == 2, 1'b0);
      check(32'(pressOut), 32'(expConv(u)));
      check(32'(alarmSeen), 32'(u == 2));
      check(32'(shotCount), 32'(u + 1));
      check(32'(outPort[2]), 32'h0);
      check(32'(outPort[9:4]), 32'h0);
    end
    run_shot(4'h0, 1'b1, 1'b0);
    check(32'(alarmSeen), 32'h0);
    check(32'(outPort[2]), 32'h1);
    delayTenths = 8'h01;
    run_shot(4'h1, 1'b0, 1'b1);
    check(32'(shotCount), 32'h6);
    countClear = 1'b1;
    @(negedge ref_clk);
    countClear = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(32'(shotCount), 32'h0);
    check(32'(outPort[2]), 32'h0);
    tally_and_finish();
  end
endmodule
